/* File: design/dac_link_pkg.sv */
// Shared constants for the serial DAC link and its two ends
package dac_link_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 16;
  localparam int RST_SEL_BIT = 22;
  localparam int MODE_HI_BIT = 21;
  localparam int MODE_LO_BIT = 20;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT_IDX = 5'h17;
  localparam logic [CNT_W-1:0] SWR_BIT_IDX  = 5'h07;
  localparam logic [CNT_W-1:0] FRAME_BITS_C = 5'h18;
  localparam logic [7:0]       SWR_BYTE     = 8'hff;
  localparam logic [FRAME_BITS-1:0] SWR_WORD = 24'hffffff;

  // ****************************************************************
  // Operating modes and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_OPEN   = 2'h1;
  localparam logic [1:0] MODE_R100K  = 2'h2;
  localparam logic [1:0] MODE_R1K    = 2'h3;
  localparam logic [DATA_BITS-1:0] DAC_RESET_VAL  = 16'h0000;
  localparam logic [DATA_BITS-1:0] CODE_RESET_VAL = 16'h0000;

  // ****************************************************************
  // Controller register map
  // ****************************************************************
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_FRAME  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 2'h2;
  localparam int STATUS_BUSY_BIT   = 0;
  localparam int CTRL_IDLE_LOW_BIT = 0;
  localparam logic CTRL_RESET_VAL = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int SCLK_MAX_MHZ    = 30;
  localparam int SYNC_HIGH_MIN_NS = 33;
  localparam int SCLK_PERIOD_CYC =
    (1000000 + SCLK_MAX_MHZ * CLK_PERIOD_PS - 1) / (SCLK_MAX_MHZ * CLK_PERIOD_PS);
  localparam int SYNC_GAP_CYC_I =
    (SYNC_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] HALF_HI_CYC = TMR_W'((SCLK_PERIOD_CYC + 1) / 2);
  localparam logic [TMR_W-1:0] HALF_LO_CYC = TMR_W'(SCLK_PERIOD_CYC / 2);
  localparam logic [TMR_W-1:0] SYNC_GAP_CYC = TMR_W'(SYNC_GAP_CYC_I);

endpackage : dac_link_pkg

/* File: design/dac_link_if.sv */
// Three-wire write-only link between controller and DAC
interface dac_link_if;
  logic sync_n;
  logic sclk;
  logic sdi;

  modport host
  (
    output sync_n,
    output sclk,
    output sdi
  );

  modport device
  (
    input sync_n,
    input sclk,
    input sdi
  );
endinterface : dac_link_if

/* File: design/dac_serial_load.sv */
// DAC end: serial load, frame execution and output mode control
module dac_serial_load
(
  input  wire logic                                clk,
  input  wire logic                                rst,
  dac_link_if.device                               link,
  output logic [dac_link_pkg::DATA_BITS-1:0]       dac_code,
  output logic [dac_link_pkg::DATA_BITS-1:0]       reset_code,
  output logic [1:0]                               mode,
  output logic                                     core_on,
  output logic                                     out_open,
  output logic                                     out_100k,
  output logic                                     out_1k
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed
  {
    logic [dac_link_pkg::CNT_W-1:0]        cnt;
    logic [dac_link_pkg::FRAME_BITS-2:0]   shreg;
    logic                                  done;
  } frame_t;

  typedef struct packed
  {
    logic [dac_link_pkg::FRAME_BITS-1:0]   word;
    logic                                  frame_tog;
    logic                                  swr_tog;
  } hold_t;

  typedef struct packed
  {
    logic                                  frame_s1;
    logic                                  frame_s2;
    logic                                  frame_seen;
    logic                                  swr_s1;
    logic                                  swr_s2;
    logic                                  swr_seen;
    logic [dac_link_pkg::DATA_BITS-1:0]    dac_code;
    logic [dac_link_pkg::DATA_BITS-1:0]    reset_code;
    logic [1:0]                            mode;
    logic                                  core_on;
    logic                                  out_open;
    logic                                  out_100k;
    logic                                  out_1k;
  } core_t;

  localparam frame_t FRAME_RST = '{default: '0};
  localparam hold_t  HOLD_RST  = '{default: '0};
  localparam core_t  CORE_RST  = '{
    dac_code:   dac_link_pkg::DAC_RESET_VAL,
    reset_code: dac_link_pkg::CODE_RESET_VAL,
    mode:       dac_link_pkg::MODE_NORMAL,
    core_on:    1'b1,
    default:    '0
  };

  frame_t fr;
  frame_t next_fr;
  hold_t  hd;
  hold_t  next_hd;
  core_t  cs;
  core_t  next_cs;
  logic   frame_clr;
  logic [7:0] first_byte;

  // ****************************************************************
  // Link side, clocked by the falling serial clock
  // ****************************************************************
  // Sync high holds the shifter clear, so a rise mid-frame throws away
  // whatever was shifted and the next sync fall starts from bit zero.
  assign frame_clr = rst | link.sync_n;

  assign first_byte = {fr.shreg[6:0], link.sdi};

  always_comb
  begin
    next_fr = fr;
    next_hd = hd;
    if (!fr.done)
    begin
      next_fr.shreg = {fr.shreg[dac_link_pkg::FRAME_BITS-3:0], link.sdi};
      next_fr.cnt   = fr.cnt + 5'h01;
      // Upper byte all ones starts a software reset that survives sync
      if (fr.cnt == dac_link_pkg::SWR_BIT_IDX && first_byte == dac_link_pkg::SWR_BYTE)
      begin
        next_hd.swr_tog = ~hd.swr_tog;
      end
      if (fr.cnt == dac_link_pkg::LAST_BIT_IDX)
      begin
        next_fr.done      = 1'b1;
        next_hd.word      = {fr.shreg, link.sdi};
        next_hd.frame_tog = ~hd.frame_tog;
      end
    end
  end

  always_ff @(negedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      fr <= FRAME_RST;
    end
    else
    begin
      fr <= next_fr;
    end
  end

  // Captured frame and event toggles outlive the sync rise
  always_ff @(negedge link.sclk or posedge rst)
  begin
    if (rst)
    begin
      hd <= HOLD_RST;
    end
    else
    begin
      hd <= next_hd;
    end
  end

  // ****************************************************************
  // Core side, clocked by clk
  // ****************************************************************
  // The captured word is held for a whole frame after its toggle flips,
  // far longer than the toggle takes to cross, so it is read directly.
  always_comb
  begin
    next_cs            = cs;
    next_cs.frame_s1   = hd.frame_tog;
    next_cs.frame_s2   = cs.frame_s1;
    next_cs.frame_seen = cs.frame_s2;
    next_cs.swr_s1     = hd.swr_tog;
    next_cs.swr_s2     = cs.swr_s1;
    next_cs.swr_seen   = cs.swr_s2;

    if (cs.swr_s2 != cs.swr_seen)
    begin
      // Software reset restores the stored reset code in normal mode
      next_cs.dac_code = cs.reset_code;
      next_cs.mode     = dac_link_pkg::MODE_NORMAL;
    end
    else if (cs.frame_s2 != cs.frame_seen && hd.word != dac_link_pkg::SWR_WORD)
    begin
      if (hd.word[dac_link_pkg::RST_SEL_BIT])
      begin
        next_cs.reset_code = hd.word[dac_link_pkg::DATA_BITS-1:0];
      end
      else
      begin
        next_cs.dac_code = hd.word[dac_link_pkg::DATA_BITS-1:0];
        next_cs.mode     = hd.word[dac_link_pkg::MODE_HI_BIT:dac_link_pkg::MODE_LO_BIT];
      end
    end

    // Output termination follows the mode; DAC register is left alone
    next_cs.core_on  = 1'b0;
    next_cs.out_open = 1'b0;
    next_cs.out_100k = 1'b0;
    next_cs.out_1k   = 1'b0;
    case (next_cs.mode)
      dac_link_pkg::MODE_NORMAL: next_cs.core_on  = 1'b1;
      dac_link_pkg::MODE_OPEN:   next_cs.out_open = 1'b1;
      dac_link_pkg::MODE_R100K:  next_cs.out_100k = 1'b1;
      dac_link_pkg::MODE_R1K:    next_cs.out_1k   = 1'b1;
      default:                   next_cs.core_on  = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs <= CORE_RST;
    end
    else
    begin
      cs <= next_cs;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dac_code   = cs.dac_code;
  assign reset_code = cs.reset_code;
  assign mode       = cs.mode;
  assign core_on    = cs.core_on;
  assign out_open   = cs.out_open;
  assign out_100k   = cs.out_100k;
  assign out_1k     = cs.out_1k;

endmodule : dac_serial_load

/* File: design/dac_link_host.sv */
// Controller end: sends 24-bit frames on the three-wire link
module dac_link_host
(
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic [dac_link_pkg::ADDR_W-1:0]     addr,
  input  wire logic [dac_link_pkg::FRAME_BITS-1:0] wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic [dac_link_pkg::FRAME_BITS-1:0]      rdata,
  dac_link_if.host                                 link
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {IDLE, GAP, LEAD, HIGH, LOW, TAIL} state_t;

  typedef struct packed
  {
    state_t                                st;
    logic [dac_link_pkg::TMR_W-1:0]        tmr;
    logic [dac_link_pkg::CNT_W-1:0]        idx;
    logic [dac_link_pkg::FRAME_BITS-1:0]   shreg;
    logic [dac_link_pkg::FRAME_BITS-1:0]   frame;
    logic                                  idle_low;
    logic                                  sync_n;
    logic                                  sclk;
    logic                                  sdi;
    logic [dac_link_pkg::FRAME_BITS-1:0]   rdata;
  } host_t;

  localparam host_t HOST_RST = '{
    st:       IDLE,
    idle_low: dac_link_pkg::CTRL_RESET_VAL,
    sync_n:   1'b1,
    default:  '0
  };

  host_t hs;
  host_t next_hs;
  logic  busy;

  assign busy = (hs.st != IDLE);

  // ****************************************************************
  // Register port and frame sequencer
  // ****************************************************************
  always_comb
  begin
    next_hs       = hs;
    next_hs.rdata = '0;

    if (rd)
    begin
      case (addr)
        dac_link_pkg::ADDR_FRAME:  next_hs.rdata = hs.frame;
        dac_link_pkg::ADDR_STATUS: next_hs.rdata[dac_link_pkg::STATUS_BUSY_BIT] = busy;
        dac_link_pkg::ADDR_CTRL:   next_hs.rdata[dac_link_pkg::CTRL_IDLE_LOW_BIT] = hs.idle_low;
        default:                   next_hs.rdata = '0;
      endcase
    end
    if (wr && addr == dac_link_pkg::ADDR_CTRL)
    begin
      next_hs.idle_low = wdata[dac_link_pkg::CTRL_IDLE_LOW_BIT];
    end

    if (hs.tmr != '0)
    begin
      next_hs.tmr = hs.tmr - 4'h1;
    end

    case (hs.st)
      IDLE:
      begin
        next_hs.sync_n = ~next_hs.idle_low;
        if (wr && addr == dac_link_pkg::ADDR_FRAME)
        begin
          next_hs.frame  = wdata;
          next_hs.shreg  = wdata;
          next_hs.idx    = '0;
          next_hs.sync_n = 1'b1;
          next_hs.tmr    = dac_link_pkg::SYNC_GAP_CYC - 4'h1;
          next_hs.st     = GAP;
        end
      end
      GAP:
      begin
        if (hs.tmr == '0)
        begin
          next_hs.sync_n = 1'b0;
          next_hs.tmr    = dac_link_pkg::HALF_LO_CYC - 4'h1;
          next_hs.st     = LEAD;
        end
      end
      LEAD, LOW:
      begin
        if (hs.tmr == '0 && hs.idx == dac_link_pkg::FRAME_BITS_C)
        begin
          next_hs.sync_n = ~hs.idle_low;
          next_hs.st     = IDLE;
        end
        else if (hs.tmr == '0)
        begin
          // Data changes on the rising edge, stable at the falling one
          next_hs.sclk  = 1'b1;
          next_hs.sdi   = hs.shreg[dac_link_pkg::FRAME_BITS-1];
          next_hs.shreg = {hs.shreg[dac_link_pkg::FRAME_BITS-2:0], 1'b0};
          next_hs.idx   = hs.idx + 5'h01;
          next_hs.tmr   = dac_link_pkg::HALF_HI_CYC - 4'h1;
          next_hs.st    = HIGH;
        end
      end
      HIGH:
      begin
        if (hs.tmr == '0)
        begin
          next_hs.sclk = 1'b0;
          next_hs.tmr  = dac_link_pkg::HALF_LO_CYC - 4'h1;
          next_hs.st   = LOW;
        end
      end
      TAIL:
      begin
        next_hs.st = IDLE;
      end
      default:
      begin
        next_hs.st = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs <= HOST_RST;
    end
    else
    begin
      hs <= next_hs;
    end
  end

  assign rdata       = hs.rdata;
  assign link.sync_n = hs.sync_n;
  assign link.sclk   = hs.sclk;
  assign link.sdi    = hs.sdi;

endmodule : dac_link_host

/* File: sim/dac_link_checker.sv */
// Checker for the three-wire link and the DAC end outputs
module dac_link_checker
(
  input wire logic                                  clk,
  input wire logic                                  rst,
  input wire logic                                  sync_n,
  input wire logic                                  sclk,
  input wire logic                                  sdi,
  input wire logic [dac_link_pkg::DATA_BITS-1:0]    dac_code,
  input wire logic [dac_link_pkg::DATA_BITS-1:0]    reset_code,
  input wire logic [1:0]                            mode,
  input wire logic                                  core_on,
  input wire logic                                  out_open,
  input wire logic                                  out_100k,
  input wire logic                                  out_1k
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Falling serial-clock edges seen since the last sync fall
  // ****************************************************************
  logic       sclk_q;
  logic       sync_q;
  logic [4:0] falls;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
      falls  <= 5'h00;
    end
    else
    begin
      sclk_q <= sclk;
      sync_q <= sync_n;
      if (sync_q && !sync_n)
        falls <= 5'h00;
      else if (sclk_q && !sclk && !sync_n)
        falls <= falls + 5'h01;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_idle_clk;
    sync_n |-> !sclk;
  endproperty
  property p_gap;
    $rose(sync_n) |-> sync_n [*8] ##1 sync_n;
  endproperty
  property p_clk_high;
    $rose(sclk) |-> sclk [*5] ##1 !sclk;
  endproperty
  property p_clk_low;
    $fell(sclk) && falls != 5'h17 |-> !sclk [*4] ##1 sclk;
  endproperty
  property p_sdi_steady;
    $fell(sclk) |-> $stable(sdi);
  endproperty
  property p_max_bits;
    falls <= 5'h18;
  endproperty
  property p_exec_count;
    $changed(mode) && mode != dac_link_pkg::MODE_NORMAL |-> falls == 5'h18;
  endproperty
  property p_rcode_only;
    $changed(reset_code) |-> $stable(mode) && $stable(dac_code);
  endproperty
  property p_one_term;
    $onehot({core_on, out_open, out_100k, out_1k});
  endproperty
  property p_term_decode;
    core_on == (mode == dac_link_pkg::MODE_NORMAL) && out_open == (mode == dac_link_pkg::MODE_OPEN)
      && out_100k == (mode == dac_link_pkg::MODE_R100K);
  endproperty

  a_idle_clk:    assert property (p_idle_clk) else $error("serial clock high outside frame");
  a_gap:         assert property (p_gap) else $error("sync high too short");
  a_clk_high:    assert property (p_clk_high) else $error("serial clock high phase wrong");
  a_clk_low:     assert property (p_clk_low) else $error("serial clock low phase wrong");
  a_sdi_steady:  assert property (p_sdi_steady) else $error("data moved at sampling edge");
  a_max_bits:    assert property (p_max_bits) else $error("more than 24 bits in frame");
  a_exec_count:  assert property (p_exec_count) else $error("mode changed before 24th bit");
  a_rcode_only:  assert property (p_rcode_only) else $error("reset code load moved output");
  a_one_term:    assert property (p_one_term) else $error("termination not one-hot");
  a_term_decode: assert property (p_term_decode) else $error("termination decode wrong");

  c_r1k:   cover property (mode == dac_link_pkg::MODE_R1K);
  c_rcode: cover property ($changed(reset_code));
  c_idle:  cover property (!sync_n && !sclk && falls == 5'h18);
endmodule : dac_link_checker

/* File: sim/dac_serial_load_control_test.sv */
// Testbench: controller and DAC end joined by the link, plus a bench-driven link
module dac_serial_load_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic [1:0]  addr;
  logic [23:0] wdata;
  logic        wr;
  logic        rd;
  logic [23:0] rdata;
  logic [15:0] dac_code;
  logic [15:0] reset_code;
  logic [1:0]  mode;
  logic        core_on;
  logic        out_open;
  logic        out_100k;
  logic        out_1k;
  logic [15:0] dac_code2;
  logic [15:0] reset_code2;
  logic [1:0]  mode2;
  logic [23:0] v;
  int          n_fail;
  int          n_compared;
  int          cycles;

  dac_link_if link ();
  dac_link_if link2 ();

  dac_link_host dac_link_host_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  dac_serial_load dac_serial_load_i (.clk(clk), .rst(rst), .link(link), .dac_code(dac_code),
    .reset_code(reset_code), .mode(mode), .core_on(core_on), .out_open(out_open),
    .out_100k(out_100k), .out_1k(out_1k));
  dac_serial_load dac_serial_load_i2 (.clk(clk), .rst(rst), .link(link2), .dac_code(dac_code2),
    .reset_code(reset_code2), .mode(mode2), .core_on(), .out_open(), .out_100k(), .out_1k());
  dac_link_checker dac_link_checker_i (.clk(clk), .rst(rst), .sync_n(link.sync_n),
    .sclk(link.sclk), .sdi(link.sdi), .dac_code(dac_code), .reset_code(reset_code),
    .mode(mode), .core_on(core_on), .out_open(out_open), .out_100k(out_100k), .out_1k(out_1k));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task end_of_test;
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task bus_wr(input logic [1:0] a, input logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [1:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task wait_idle;
    int i;
    for (i = 0; i < 400; i++)
    begin
      bus_rd(dac_link_pkg::ADDR_STATUS, v);
      if (v[0] === 1'b0)
        break;
    end
    // A sequencer that never goes idle counts as a mismatch
    chk("busy", 24'h000000, v);
    repeat (6) @(posedge clk);
  endtask : wait_idle

  task frame(input logic [23:0] w);
    bus_wr(dac_link_pkg::ADDR_FRAME, w);
    wait_idle();
  endtask : frame

  task out_chk(input logic [15:0] d, input logic [1:0] m);
    chk("dac_code", {8'h00, d}, {8'h00, dac_code});
    chk("mode", {22'h0, m}, {22'h0, mode});
  endtask : out_chk

  task out2_chk(input logic [15:0] d, input logic [1:0] m);
    chk("dac_code2", {8'h00, d}, {8'h00, dac_code2});
    chk("mode2", {22'h0, m}, {22'h0, mode2});
  endtask : out2_chk

  // Bench link: 6 ns serial clock, data set on the rise
  task open2;
    link2.sync_n = 1'b1;
    #40;
    link2.sync_n = 1'b0;
    #3;
  endtask : open2

  task bits2(input logic [23:0] w, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      link2.sdi  = w[23-i];
      link2.sclk = 1'b1;
      #3;
      link2.sclk = 1'b0;
      #3;
    end
    // Idle data shows the inverse, then settles before the next burst
    link2.sdi = ~link2.sdi;
    #3;
  endtask : bits2

  task close2;
    #20;
    link2.sync_n = 1'b1;
    repeat (8) @(posedge clk);
  endtask : close2

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    addr = 2'h0;
    wdata = 24'h000000;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    link2.sync_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    out_chk(16'h0000, dac_link_pkg::MODE_NORMAL);
    chk("reset_code", 24'h000000, {8'h00, reset_code});
    bus_rd(dac_link_pkg::ADDR_CTRL, v);
    chk("ctrl", 24'h000000, v);
    bus_rd(2'h3, v);
    chk("unmapped", 24'h000000, v);
    frame(24'h00a5c3);
    out_chk(16'ha5c3, dac_link_pkg::MODE_NORMAL);
    for (int m = 1; m < 4; m++)
    begin
      frame({2'b00, 2'(m), 4'h0, 16'h1000 + 16'(m)});
      out_chk(16'h1000 + 16'(m), 2'(m));
      chk("term", 24'(4'h1 << m), {20'h0, out_1k, out_100k, out_open, core_on});
    end
    bus_wr(dac_link_pkg::ADDR_FRAME, 24'h007777);
    bus_wr(dac_link_pkg::ADDR_FRAME, 24'h008888);
    wait_idle();
    out_chk(16'h7777, dac_link_pkg::MODE_NORMAL);
    frame(24'h403c3c);
    out_chk(16'h7777, dac_link_pkg::MODE_NORMAL);
    chk("reset_code", 24'h003c3c, {8'h00, reset_code});
    bus_wr(dac_link_pkg::ADDR_CTRL, 24'h000001);
    bus_rd(dac_link_pkg::ADDR_CTRL, v);
    chk("ctrl", 24'h000001, v);
    frame(24'h205555);
    chk("sync_n", 24'h000000, {23'h0, link.sync_n});
    out_chk(16'h5555, dac_link_pkg::MODE_R100K);
    frame(24'hffffff);
    out_chk(16'h3c3c, dac_link_pkg::MODE_NORMAL);
    open2();
    bits2(24'h201234, 24);
    close2();
    out2_chk(16'h1234, dac_link_pkg::MODE_R100K);
    open2();
    bits2(24'h05abcd, 10);
    close2();
    out2_chk(16'h1234, dac_link_pkg::MODE_R100K);
    open2();
    bits2(24'h40beef, 24);
    close2();
    out2_chk(16'h1234, dac_link_pkg::MODE_R100K);
    chk("reset_code2", 24'h00beef, {8'h00, reset_code2});
    open2();
    bits2(24'h311111, 24);
    bits2(24'h002222, 24);
    close2();
    out2_chk(16'h1111, dac_link_pkg::MODE_R1K);
    open2();
    bits2(24'hff0000, 8);
    close2();
    out2_chk(16'hbeef, dac_link_pkg::MODE_NORMAL);
    open2();
    bits2(24'h10abcd, 8);
    bits2(24'habcd00, 8);
    bits2(24'hcd0000, 8);
    close2();
    out2_chk(16'habcd, dac_link_pkg::MODE_OPEN);
    end_of_test();
  end
endmodule : dac_serial_load_control_test
